// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  localparam int GTS = 40;
  localparam int UVC = 20;
  localparam int INACT = 120;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slvErr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic selReq = 0, enReq = 0, coreSupplyUndervoltage = 1, ioSupplyUndervoltage = 0;
  logic batterySupplyUndervoltage = 0, remoteWakePattern = 0, localWakeEvent = 0;
  logic localFailure = 0, busRxState = 1, standbySelect_n, enablePin, driverEnable;
  logic receiverEnable, monitorEnable, rxdOut, rxdOe, supplyInhibitOut, supplyInhibitOe, faultOut_n;
  int errorCnt = 0, comparisons = 0, cycles = 0;
  tmc_mode_ctrl #(.GTS_CYC(GTS), .UV_CYC(UVC), .INACT_CYC(INACT)) dut_u (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .standbySelect_n, .enablePin, .coreSupplyUndervoltage, .ioSupplyUndervoltage,
    .batterySupplyUndervoltage, .remoteWakePattern, .localWakeEvent, .localFailure, .busRxState,
    .driverEnable, .receiverEnable, .monitorEnable, .rxdOut, .rxdOe, .supplyInhibitOut,
    .supplyInhibitOe, .faultOut_n);
  tmc_host_model #(.HOLD(4)) host_u (.clk, .arst_n, .selReq, .enReq, .standbySelect_n, .enablePin);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errorCnt++;
      stopTest();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic expMode(input logic [2:0] m);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[2:0], m);
  endtask
  task automatic outs(input logic [3:0] e);
    chk({driverEnable, receiverEnable, monitorEnable, supplyInhibitOe}, e);
  endtask
  task automatic pins(input logic s, input logic e);
    selReq <= s;
    enReq <= e;
    wt(12);
  endtask
  task automatic testReset();
    wt(UVC + 4);
    expMode(TMC_STANDBY);
    outs(4'h3);
    chk(supplyInhibitOut, 1'h1);
    coreSupplyUndervoltage <= 1'h0;
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[1], 1'h1);
    apb(1'h0, 12'h00C, 32'h0);
    chk(slvErr, 1'h1);
    chk(rd, 32'h0);
    apb(1'h1, 12'h000, 32'h2);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    apb(1'h1, 12'h000, 32'h0);
    $display("reset test done");
  endtask
  task automatic testActive();
    pins(1'h1, 1'h0);
    expMode(TMC_SILENT);
    outs(4'h5);
    chk(faultOut_n, 1'h0);
    pins(1'h1, 1'h1);
    expMode(TMC_NORMAL);
    outs(4'hD);
    busRxState <= 1'h0;
    wt(6);
    chk(rxdOut, 1'h0);
    busRxState <= 1'h1;
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[1:0], 2'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[3], 1'h0);
    pins(1'h1, 1'h0);
    wt(INACT + 20);
    expMode(TMC_SILENT);
    $display("active test done");
  endtask
  task automatic testSwe();
    pins(1'h0, 1'h0);
    expMode(TMC_STANDBY);
    outs(4'h3);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd[3], 1'h1);
    pins(1'h1, 1'h0);
    expMode(TMC_SILENT);
    wt(INACT);
    expMode(TMC_SLEEP);
    outs(4'h2);
    pins(1'h1, 1'h1);
    pins(1'h1, 1'h0);
    expMode(TMC_SLEEP);
    pins(1'h0, 1'h1);
    pins(1'h1, 1'h1);
    expMode(TMC_SLEEP);
    pins(1'h1, 1'h0);
    expMode(TMC_SILENT);
    $display("sleep wake error test done");
  endtask
  task automatic testGoToSleep();
    pins(1'h1, 1'h1);
    selReq <= 1'h0;
    wt(6);
    expMode(TMC_GOTOSLEEP);
    chk(supplyInhibitOe, 1'h1);
    wt(GTS);
    expMode(TMC_SLEEP);
    chk(supplyInhibitOe, 1'h0);
    pins(1'h0, 1'h0);
    pins(1'h1, 1'h0);
    expMode(TMC_SILENT);
    $display("go to sleep test done");
  endtask
  task automatic testUndervoltage();
    pins(1'h1, 1'h1);
    ioSupplyUndervoltage <= 1'h1;
    wt(6);
    expMode(TMC_STANDBY);
    wt(UVC);
    expMode(TMC_SLEEP);
    pins(1'h0, 1'h1);
    pins(1'h1, 1'h1);
    expMode(TMC_SLEEP);
    ioSupplyUndervoltage <= 1'h0;
    pins(1'h0, 1'h1);
    pins(1'h1, 1'h1);
    expMode(TMC_NORMAL);
    $display("undervoltage test done");
  endtask
  task automatic testWake();
    pins(1'h0, 1'h1);
    wt(GTS);
    expMode(TMC_SLEEP);
    localWakeEvent <= 1'h1;
    @(posedge clk);
    localWakeEvent <= 1'h0;
    wt(8);
    expMode(TMC_STANDBY);
    chk({rxdOe, rxdOut}, 2'h2);
    wt(GTS + 10);
    expMode(TMC_STANDBY);
    pins(1'h1, 1'h1);
    expMode(TMC_NORMAL);
    chk(faultOut_n, 1'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd[0], 1'h0);
    $display("wake test done");
  endtask
  task automatic testControl();
    pins(1'h0, 1'h0);
    expMode(TMC_STANDBY);
    apb(1'h1, 12'h000, 32'h1);
    expMode(TMC_GOTOSLEEP);
    wt(GTS);
    expMode(TMC_SLEEP);
    apb(1'h1, 12'h000, 32'h2);
    remoteWakePattern <= 1'h1;
    @(posedge clk);
    remoteWakePattern <= 1'h0;
    wt(8);
    expMode(TMC_STANDBY);
    chk(rxdOut, 1'h0);
    wt(INACT + 10);
    expMode(TMC_STANDBY);
    pins(1'h1, 1'h1);
    expMode(TMC_NORMAL);
    chk(faultOut_n, 1'h1);
    $display("control test done");
  endtask
  initial begin
    wt(3);
    arst_n <= 1'h1;
    @(posedge clk);
    testReset();
    testActive();
    testSwe();
    testGoToSleep();
    testUndervoltage();
    testWake();
    testControl();
    stopTest();
  end
endmodule

// ==== tmc_host_model.sv ====
module tmc_host_model #(
  parameter int HOLD = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requested pin levels
  input wire logic selReq,
  input wire logic enReq,
  // pins to the transceiver
  output logic standbySelect_n,
  output logic enablePin
);
  timeunit 1ns;
  timeprecision 1ns;
  int holdCnt;
  // select can rise at the same edge as an enable edge; after that edge, only once the hold has run out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standbySelect_n <= 1'h0;
      enablePin <= 1'h0;
      holdCnt <= 0;
    end else begin
      enablePin <= enReq;
      if (enReq != enablePin && !standbySelect_n) holdCnt <= HOLD;
      else if (holdCnt > 0) holdCnt <= holdCnt - 1;
      standbySelect_n <= selReq && (holdCnt == 0 || standbySelect_n);
    end
  end
endmodule

// ==== tmc_mode_ctrl.sv ====
`include "tmc_params.svh"
// What this block does
// RQ1 - mode from standby-select, enable, supplies, wakes
// RQ2 - normal: driver and receiver on
// RQ3 - silent: receiver only, inhibit on
// RQ4 - standby: monitor only, rxd low on wake
// RQ5 - go-to-sleep times out to sleep, inhibit off
// RQ6 - uv timers armed after first rise
// RQ7 - armed uv timer expiry forces sleep
// RQ8 - sleep-wake-error timer starts standby, clears normal
// RQ9 - silent from standby keeps timer, expiry sleeps
// RQ10 - silent from normal: timer inactive
// RQ11 - standby inactivity expiry forces sleep
// RQ12 - select rise wakes pin sleep; enable picks
// RQ13 - pin exit ignored under io undervoltage
// RQ14 - timer sleep: select high plus enable edge
// RQ15 - entered high: enable toggle with select low first
// RQ16 - host holds select low mode-hold time
// RQ17 - normal entry clears wake and power flags
// RQ18 - silent: fault shows power-on or local failure
// RQ19 - normal: fault shows wake source
// RQ20 - pending wake keeps standby, not sleep
// RQ21 - exactly six modes
// RQ22 - bus pattern or local wake leaves sleep
// RQ23 - io undervoltage to standby then sleep
// RQ24 - durations are counter parameters
module tmc_mode_ctrl import tmc_pkg::*; #(
  parameter int unsigned GTS_CYC = `TMC_GTS_CYC, // RQ24
  parameter longint unsigned UV_CYC = `TMC_UV_CYC,
  parameter longint unsigned INACT_CYC = `TMC_INACT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins and conditions (asynchronous)
  input wire logic standbySelect_n,
  input wire logic enablePin,
  input wire logic coreSupplyUndervoltage,
  input wire logic ioSupplyUndervoltage,
  input wire logic batterySupplyUndervoltage,
  input wire logic remoteWakePattern,
  input wire logic localWakeEvent,
  input wire logic localFailure,
  input wire logic busRxState,
  // outputs
  output logic driverEnable,
  output logic receiverEnable,
  output logic monitorEnable,
  output logic rxdOut,
  output logic rxdOe,
  output logic supplyInhibitOut,
  output logic supplyInhibitOe,
  output logic faultOut_n
);
  // two-stage synchronisers, one generate loop
  localparam int NSYNC = 9;
  localparam logic [NSYNC-1:0] SYNC_RST = 9'h11C; // supply monitors start in undervoltage, bus idle high
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncA_reg;
  logic [NSYNC-1:0] syncB_reg;
  assign rawIn = {busRxState, localFailure, localWakeEvent, remoteWakePattern, batterySupplyUndervoltage,
                  ioSupplyUndervoltage, coreSupplyUndervoltage, enablePin, standbySelect_n};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          syncA_reg[gi] <= SYNC_RST[gi];
          syncB_reg[gi] <= SYNC_RST[gi];
        end else begin
          syncA_reg[gi] <= rawIn[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate
  wire stbSel = syncB_reg[0];
  wire enPin = syncB_reg[1];
  wire uvCore = syncB_reg[2];
  wire uvIo = syncB_reg[3];
  wire uvBat = syncB_reg[4];
  wire wakeBus = syncB_reg[5];
  wire wakeLocal = syncB_reg[6];
  wire failLocal = syncB_reg[7];
  wire busRx = syncB_reg[8];

  logic stbSelD_reg;
  logic enPinD_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stbSelD_reg <= 1'b0;
      enPinD_reg <= 1'b0;
    end else begin
      stbSelD_reg <= stbSel;
      enPinD_reg <= enPin;
    end
  end
  wire stbRise = stbSel && !stbSelD_reg;
  wire enRise = enPin && !enPinD_reg;
  wire enFall = !enPin && enPinD_reg;

  tmc_mode_t mode_reg, mode_next;
  tmc_slpcause_t cause_reg, cause_next;
  logic swe_reg, swe_next;
  logic [31:0] gtsCnt_reg;
  logic [47:0] sweCnt_reg;
  logic [47:0] uvCoreCnt_reg;
  logic [47:0] uvIoCnt_reg;
  logic coreArm_reg;
  logic ioArm_reg;
  logic wakeReq_reg;
  logic powerOn_reg;
  logic wakeSrcLocal_reg;
  logic seqArmed_reg;
  logic seqArmed_next;
  logic [31:0] ctrl_reg;

  // software can force a sleep request and disable the sleep-wake-error timer
  wire swGoSleep = ctrl_reg[0];
  wire sweDisable = ctrl_reg[1];

  wire gtsDone = gtsCnt_reg >= 32'(GTS_CYC); // RQ5
  wire sweDone = swe_reg && !sweDisable && (sweCnt_reg >= 48'(INACT_CYC)); // RQ11
  wire uvExpire = (coreArm_reg && uvCoreCnt_reg >= 48'(UV_CYC)) ||
                  (ioArm_reg && uvIoCnt_reg >= 48'(UV_CYC)); // RQ7
  wire wakePending = wakeReq_reg; // RQ20
  wire pinExitPin = stbRise && !uvIo; // RQ12 RQ13
  wire pinExitSwe = seqArmed_reg && stbSel && (enRise || enFall) && !uvIo; // RQ14 RQ13

  always_comb begin
    mode_next = mode_reg;
    cause_next = cause_reg;
    swe_next = swe_reg;
    seqArmed_next = seqArmed_reg;
    case (mode_reg) // RQ21
      TMC_OFF: begin
        if (!uvBat) begin
          mode_next = TMC_STANDBY;
          swe_next = 1'b1;
        end
      end
      TMC_NORMAL, TMC_SILENT, TMC_STANDBY, TMC_GOTOSLEEP: begin
        if (uvExpire) begin
          mode_next = TMC_SLEEP; // RQ7 RQ23
          cause_next = TMC_SLP_PIN;
          swe_next = 1'b0;
        end else if (sweDone && (mode_reg == TMC_STANDBY || mode_reg == TMC_SILENT)) begin
          mode_next = TMC_SLEEP; // RQ9 RQ11
          cause_next = TMC_SLP_SWE;
          swe_next = 1'b0;
          seqArmed_next = !stbSel; // RQ15
        end else if (uvIo) begin
          mode_next = TMC_STANDBY; // RQ23
          if (mode_reg != TMC_STANDBY) begin
            swe_next = 1'b1; // RQ8
          end
        end else if (stbSel && enPin) begin
          mode_next = TMC_NORMAL; // RQ1
          swe_next = 1'b0; // RQ8
        end else if (stbSel) begin
          if (mode_reg != TMC_SILENT) begin
            mode_next = TMC_SILENT;
            swe_next = (mode_reg != TMC_NORMAL) && swe_reg; // RQ9 RQ10
          end
        end else if ((enPin || swGoSleep) && !wakePending) begin
          mode_next = (mode_reg == TMC_GOTOSLEEP && gtsDone) ? TMC_SLEEP : TMC_GOTOSLEEP; // RQ5
          cause_next = TMC_SLP_PIN;
          swe_next = 1'b0;
        end else begin
          if (mode_reg != TMC_STANDBY) begin
            swe_next = 1'b1; // RQ8
          end
          mode_next = TMC_STANDBY; // RQ20
        end
      end
      TMC_SLEEP: begin
        if (!stbSel && (enRise || enFall)) begin
          seqArmed_next = 1'b1; // RQ15
        end
        if (wakeBus || wakeLocal) begin
          mode_next = TMC_STANDBY; // RQ22
          swe_next = 1'b1;
        end else if ((cause_reg == TMC_SLP_PIN && pinExitPin) || (cause_reg == TMC_SLP_SWE && pinExitSwe)) begin
          mode_next = (cause_reg == TMC_SLP_PIN ? enPin : enRise) ? TMC_NORMAL : TMC_SILENT; // RQ12 RQ14
          swe_next = 1'b0;
        end
      end
      default: mode_next = TMC_OFF;
    endcase
    if (uvBat) begin
      mode_next = TMC_OFF;
      swe_next = 1'b0;
    end
    if (mode_next == TMC_SLEEP && mode_reg != TMC_SLEEP && cause_next == TMC_SLP_PIN) begin
      seqArmed_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= TMC_OFF;
      cause_reg <= TMC_SLP_PIN;
      swe_reg <= 1'b0;
      seqArmed_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cause_reg <= cause_next;
      swe_reg <= swe_next;
      seqArmed_reg <= seqArmed_next;
    end
  end

  wire enterNormal = (mode_next == TMC_NORMAL) && (mode_reg != TMC_NORMAL);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gtsCnt_reg <= '0;
      sweCnt_reg <= '0;
      uvCoreCnt_reg <= '0;
      uvIoCnt_reg <= '0;
      coreArm_reg <= 1'b0;
      ioArm_reg <= 1'b0;
    end else begin
      gtsCnt_reg <= (mode_reg == TMC_GOTOSLEEP && !gtsDone) ? gtsCnt_reg + 32'd1 :
                    (mode_reg == TMC_GOTOSLEEP ? gtsCnt_reg : '0); // RQ5
      sweCnt_reg <= (swe_next && swe_reg && !sweDone) ? sweCnt_reg + 48'd1 : (swe_next ? sweCnt_reg : '0); // RQ8
      coreArm_reg <= coreArm_reg || !uvCore; // RQ6
      ioArm_reg <= ioArm_reg || !uvIo; // RQ6
      uvCoreCnt_reg <= (coreArm_reg && uvCore && mode_reg != TMC_SLEEP) ? uvCoreCnt_reg + 48'd1 : '0; // RQ7
      uvIoCnt_reg <= (ioArm_reg && uvIo && mode_reg != TMC_SLEEP) ? uvIoCnt_reg + 48'd1 : '0; // RQ7
    end
  end

  // wake flag: a wake in the same cycle as normal entry wins
  wire wakeHit = (wakeBus || wakeLocal) && (mode_reg == TMC_STANDBY || mode_reg == TMC_SLEEP ||
                 mode_reg == TMC_GOTOSLEEP);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeReq_reg <= 1'b0;
      powerOn_reg <= 1'b1;
      wakeSrcLocal_reg <= 1'b0;
    end else begin
      wakeReq_reg <= wakeHit || (wakeReq_reg && !enterNormal); // RQ17
      powerOn_reg <= (mode_reg == TMC_OFF) || (powerOn_reg && !enterNormal); // RQ17
      if (wakeHit) begin
        wakeSrcLocal_reg <= wakeLocal; // RQ19
      end
    end
  end

  // outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      driverEnable <= 1'b0;
      receiverEnable <= 1'b0;
      monitorEnable <= 1'b0;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
      supplyInhibitOut <= 1'b0;
      supplyInhibitOe <= 1'b0;
      faultOut_n <= 1'b1;
    end else begin
      driverEnable <= (mode_reg == TMC_NORMAL); // RQ2 RQ3
      receiverEnable <= (mode_reg == TMC_NORMAL) || (mode_reg == TMC_SILENT); // RQ2 RQ3
      monitorEnable <= (mode_reg == TMC_STANDBY) || (mode_reg == TMC_GOTOSLEEP) || (mode_reg == TMC_SLEEP); // RQ4
      rxdOe <= (mode_reg != TMC_OFF) && !uvIo;
      case (mode_reg)
        TMC_NORMAL, TMC_SILENT: rxdOut <= busRx; // RQ2 RQ3
        TMC_STANDBY: rxdOut <= !wakeReq_reg; // RQ4
        default: rxdOut <= 1'b1;
      endcase
      supplyInhibitOut <= 1'b1;
      supplyInhibitOe <= (mode_reg == TMC_NORMAL) || (mode_reg == TMC_SILENT) ||
                         (mode_reg == TMC_STANDBY) || (mode_reg == TMC_GOTOSLEEP); // RQ3 RQ4 RQ5
      case (mode_reg)
        TMC_SILENT: faultOut_n <= !(powerOn_reg || failLocal); // RQ18
        TMC_NORMAL: faultOut_n <= !wakeSrcLocal_reg; // RQ19
        default: faultOut_n <= 1'b1;
      endcase
    end
  end

  // apb slave, zero wait states
  wire apbWr = psel && penable && pwrite;
  wire hitCtrl = (paddr == `TMC_ADDR_CTRL);
  wire hitStat = (paddr == `TMC_ADDR_STAT);
  wire hitFlags = (paddr == `TMC_ADDR_FLAGS);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `TMC_CTRL_RESET;
    end else if (apbWr && hitCtrl) begin
      ctrl_reg <= {30'h0, pwdata[1:0]};
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitCtrl || hitStat || hitFlags);
  assign prdata = hitCtrl ? ctrl_reg :
                  hitStat ? {28'h000_0000, swe_reg, mode_reg} :
                  hitFlags ? {28'h000_0000, wakeSrcLocal_reg, seqArmed_reg, powerOn_reg, wakeReq_reg} : 32'h0000_0000;

  a_normal_drives: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
    mode_reg == TMC_NORMAL |=> driverEnable && receiverEnable) else $error("normal mode not driving");
  a_silent_nodrive: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
    mode_reg == TMC_SILENT |=> !driverEnable && receiverEnable && supplyInhibitOe)
    else $error("silent mode outputs wrong");
  a_sleep_inhoff: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
    mode_reg == TMC_SLEEP |=> !supplyInhibitOe) else $error("inhibit on in sleep");
  a_normal_clears: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
    enterNormal && !wakeHit |=> !wakeReq_reg && !powerOn_reg) else $error("flags not cleared");
  a_normal_swe: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
    mode_reg == TMC_NORMAL |-> !swe_reg) else $error("swe timer active in normal");
  a_standby_swe: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
    mode_reg == TMC_STANDBY |-> swe_reg) else $error("swe timer idle in standby");
  a_wake_hold: assert property (@(posedge clk) disable iff (!arst_n) // RQ20
    mode_reg == TMC_STANDBY && wakePending && !uvBat && !uvExpire && !sweDone && !stbSel |=> mode_reg == TMC_STANDBY)
    else $error("left standby with wake pending");
  a_io_exit_block: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
    mode_reg == TMC_SLEEP && uvIo && !wakeBus && !wakeLocal && !uvBat |=> mode_reg == TMC_SLEEP)
    else $error("pin exit under io undervoltage");
  a_silent_fault: assert property (@(posedge clk) disable iff (!arst_n) // RQ18
    mode_reg == TMC_SILENT && powerOn_reg |=> !faultOut_n) else $error("power-on not reported");
  a_gts_inh: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
    mode_reg == TMC_GOTOSLEEP |=> supplyInhibitOe && !driverEnable && !receiverEnable)
    else $error("go-to-sleep outputs wrong");
  a_gts_wait: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
    mode_reg == TMC_GOTOSLEEP && !gtsDone && !uvExpire |=> mode_reg != TMC_SLEEP)
    else $error("sleep before go-to-sleep time");
  a_standby_rxd: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
    mode_reg == TMC_STANDBY && wakeReq_reg |=> !rxdOut && monitorEnable && !driverEnable && !receiverEnable)
    else $error("standby wake not shown on rxd");
  a_off_outputs: assert property (@(posedge clk) disable iff (!arst_n) // RQ21
    mode_reg == TMC_OFF |=> !driverEnable && !receiverEnable && !supplyInhibitOe && !rxdOe)
    else $error("outputs active in off mode");
  a_swe_silent: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
    mode_reg == TMC_NORMAL && mode_next == TMC_SILENT |=> !swe_reg) else $error("swe timer on after normal");
  a_normal_wake: assert property (@(posedge clk) disable iff (!arst_n) // RQ19
    mode_reg == TMC_NORMAL && wakeSrcLocal_reg |=> !faultOut_n) else $error("local wake source not shown");
endmodule

// ==== tmc_params.svh ====
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
`define TMC_CLK_MHZ 50
`define TMC_GTS_US 50
`define TMC_GTS_CYC ((`TMC_GTS_US * `TMC_CLK_MHZ))
`define TMC_UV_US 200000
`define TMC_UV_CYC ((`TMC_UV_US * `TMC_CLK_MHZ))
`define TMC_INACT_MS 240000
`define TMC_INACT_CYC ((64'(`TMC_INACT_MS) * 64'd1000 * 64'(`TMC_CLK_MHZ)))
`define TMC_MODEHOLD_US 20
`define TMC_MODEHOLD_CYC ((`TMC_MODEHOLD_US * `TMC_CLK_MHZ))
`define TMC_ADDR_CTRL 12'h000
`define TMC_ADDR_STAT 12'h004
`define TMC_ADDR_FLAGS 12'h008
`define TMC_CTRL_RESET 32'h0000_0000
`endif

// ==== tmc_pkg.sv ====
package tmc_pkg;
  typedef enum logic [2:0] {
    TMC_OFF,
    TMC_NORMAL,
    TMC_SILENT,
    TMC_STANDBY,
    TMC_GOTOSLEEP,
    TMC_SLEEP
  } tmc_mode_t;
  typedef enum logic [1:0] {
    TMC_SLP_PIN,
    TMC_SLP_SWE
  } tmc_slpcause_t;
endpackage
